/* File: clock_ctl.v */
// Clock source selection, prescalers and control registers
//
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "clock_ctl_regs.vh"

module clock_ctl
(
  input  wire       clk,
  input  wire       rst_b,
  input  wire [2:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr,
  input  wire       rd,
  output reg  [7:0] rdata,
  input  wire       main_clk_pin,
  input  wire       osc32k_pin,
  input  wire       pll_clk_pin,
  input  wire       pll_stable,
  input  wire       main_stable,
  input  wire       power_on_detect,
  input  wire       programming_mode,
  output reg        sys_clk_en,
  output reg        slow_clk_en,
  output reg        aux1_clk_en,
  output reg        aux2_clk_en,
  output reg        pll_stop,
  output reg  [2:0] pll_mult,
  output reg        irq
);

  // ****************************************
  // Pin synchronisers and edge ticks
  // ****************************************
  // Stage one feeds stage two only; edges come from stages two and three
  reg [6:0] sync1_r;
  reg [6:0] sync2_r;
  reg [2:0] sync3_r;
  wire      main_tick;
  wire      osc_tick;
  wire      pll_tick;
  wire      pll_ok;
  wire      main_ok;
  wire      por_in;
  wire      programming_mode_in;

  // No reset here: programming mode must be seen at the reset edge,
  // and stage three tracks the pins so no false edge follows reset
  always @(posedge clk)
  begin
    sync1_r <= {programming_mode, power_on_detect, main_stable, pll_stable,
                pll_clk_pin, osc32k_pin, main_clk_pin};
    sync2_r <= sync1_r;
    sync3_r <= sync2_r[2:0];
  end

  assign main_tick = sync2_r[0] & ~sync3_r[0];
  assign osc_tick  = sync2_r[1] & ~sync3_r[1];
  assign pll_tick  = sync2_r[2] & ~sync3_r[2];
  assign pll_ok    = sync2_r[3];
  assign main_ok   = sync2_r[4];
  assign por_in    = sync2_r[5];
  assign programming_mode_in   = sync2_r[6];

  // ****************************************
  // Registers
  // ****************************************
  reg                  slow_sel_r;
  reg                  fast_source_select_r;
  reg                  pll_power_down_r;
  reg                  aux1_enable_r;
  reg                  aux2_enable_r;
  reg                  power_on_r;
  reg [7:0]            fast_clock_prescaler_r;
  reg [7:0]            slow_clock_prescaler_r;
  reg [7:0]            auxiliary_clock_prescaler_r;
  reg [`IRQ_WIDTH-1:0] irq_status_r;
  reg [`IRQ_WIDTH-1:0] irq_enable_r;
  reg [`IRQ_WIDTH-1:0] irq_event;
  reg                  fast_nxt;
  reg                  pwd_nxt;
  wire                 wr_ctl;

  assign wr_ctl = wr && (addr == `ADDR_CLOCK_RESET_CONTROL);

  // Guarded source switch; checks use the bits as they stand before the write
  always @*
  begin
    fast_nxt  = fast_source_select_r;
    pwd_nxt   = pll_power_down_r;
    irq_event = {`IRQ_WIDTH{1'b0}};
    if (wr_ctl)
    begin
      if (wdata[`BIT_FAST_SOURCE_SELECT])
        fast_nxt = 1'b1;
      else if (!pll_power_down_r && pll_ok)
        fast_nxt = 1'b0;
      else if (fast_source_select_r)
        irq_event[`IRQ_WRITE_REFUSED] = 1'b1;
      if (!wdata[`BIT_PLL_POWER_DOWN])
        pwd_nxt = 1'b0;
      else if (fast_source_select_r)
        pwd_nxt = 1'b1;
      else if (!pll_power_down_r)
        irq_event[`IRQ_WRITE_REFUSED] = 1'b1;
    end
    irq_event[`IRQ_PLL_SELECTED] = fast_source_select_r & ~fast_nxt;
    irq_event[`IRQ_POWER_ON]     = por_in;
  end

  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      slow_sel_r                  <= 1'b0;
      fast_source_select_r        <= 1'b1;
      pll_power_down_r            <= 1'b1;
      aux1_enable_r               <= 1'b0;
      aux2_enable_r               <= 1'b0;
      power_on_r                  <= 1'b1;
      slow_clock_prescaler_r      <= `SLOW_PRESCALER_RESET;
      auxiliary_clock_prescaler_r <= `AUX_PRESCALER_RESET;
      irq_status_r                <= {`IRQ_WIDTH{1'b0}};
      irq_enable_r                <= {`IRQ_WIDTH{1'b0}};
      // Programming mode keeps the earlier prescaler setting
      if (!programming_mode_in)
        fast_clock_prescaler_r <= `FAST_PRESCALER_RESET;
    end
    else
    begin
      fast_source_select_r <= fast_nxt;
      pll_power_down_r     <= pwd_nxt;
      if (wr_ctl)
      begin
        slow_sel_r    <= wdata[`BIT_SLOW_SELECT];
        aux1_enable_r <= wdata[`BIT_AUX1_ENABLE];
        aux2_enable_r <= wdata[`BIT_AUX2_ENABLE];
      end
      // Detection wins over a clearing write
      if (por_in)
        power_on_r <= 1'b1;
      else if (wr_ctl && !wdata[`BIT_POWER_ON])
        power_on_r <= 1'b0;
      // Reserved bit 7 is held at zero
      if (wr && addr == `ADDR_FAST_CLOCK_PRESCALER)
        fast_clock_prescaler_r <= {1'b0, wdata[6:0]};
      if (wr && addr == `ADDR_SLOW_CLOCK_PRESCALER)
        slow_clock_prescaler_r <= wdata;
      if (wr && addr == `ADDR_AUX_CLOCK_PRESCALER)
        auxiliary_clock_prescaler_r <= wdata;
      if (wr && addr == `ADDR_IRQ_ENABLE)
        irq_enable_r <= wdata[`IRQ_WIDTH-1:0];
      // New events win over the clear
      if (wr && addr == `ADDR_IRQ_CLEAR)
        irq_status_r <= (irq_status_r & ~wdata[`IRQ_WIDTH-1:0]) | irq_event;
      else
        irq_status_r <= irq_status_r | irq_event;
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  always @(posedge clk)
  begin
    if (!rst_b)
      rdata <= 8'h00;
    else if (rd)
    begin
      case (addr)
        `ADDR_CLOCK_RESET_CONTROL:
          rdata <= {2'b00, power_on_r, aux2_enable_r, aux1_enable_r,
                    pll_power_down_r, fast_source_select_r, slow_sel_r};
        `ADDR_FAST_CLOCK_PRESCALER:
          rdata <= fast_clock_prescaler_r;
        `ADDR_SLOW_CLOCK_PRESCALER:
          rdata <= slow_clock_prescaler_r;
        `ADDR_AUX_CLOCK_PRESCALER:
          rdata <= auxiliary_clock_prescaler_r;
        `ADDR_IRQ_STATUS:
          rdata <= {5'h00, irq_status_r};
        `ADDR_IRQ_ENABLE:
          rdata <= {5'h00, irq_enable_r};
        default:
          rdata <= 8'h00;
      endcase
    end
    else
      rdata <= 8'h00;
  end

  // ****************************************
  // System clock prescaler
  // ****************************************
  // Divisor is compared on every tick, so a change takes hold at once; software keeps it still on PLL
  reg  [3:0] sys_cnt_r;
  wire       sys_src_tick;
  wire [3:0] fast_divisor;

  assign fast_divisor = fast_clock_prescaler_r[`FAST_DIV_MSB:`FAST_DIV_LSB];
  assign sys_src_tick = fast_source_select_r ? main_tick : pll_tick;

  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      sys_cnt_r  <= 4'h0;
      sys_clk_en <= 1'b0;
    end
    else
    begin
      sys_clk_en <= 1'b0;
      if (sys_src_tick)
      begin
        if (sys_cnt_r >= fast_divisor)
        begin
          sys_cnt_r  <= 4'h0;
          sys_clk_en <= 1'b1;
        end
        else
          sys_cnt_r <= sys_cnt_r + 4'h1;
      end
    end
  end

  // ****************************************
  // Slow clock prescaler and select
  // ****************************************
  reg  [8:0] slow_cnt_r;
  wire [8:0] slow_last;

  assign slow_last = {slow_clock_prescaler_r, 1'b1};

  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      slow_cnt_r  <= 9'h000;
      slow_clk_en <= 1'b0;
    end
    else
    begin
      slow_clk_en <= slow_sel_r ? osc_tick : 1'b0;
      if (main_tick)
      begin
        if (slow_cnt_r >= slow_last)
        begin
          slow_cnt_r <= 9'h000;
          if (!slow_sel_r)
            slow_clk_en <= 1'b1;
        end
        else
          slow_cnt_r <= slow_cnt_r + 9'h001;
      end
    end
  end

  // ****************************************
  // Auxiliary prescalers
  // ****************************************
  // Counter held cleared while stopped, so restart gives a full period
  wire [1:0] aux_run;
  wire [1:0] aux_pulse;

  assign aux_run = {aux2_enable_r & main_ok, aux1_enable_r & main_ok};

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : aux_div
      reg  [3:0] cnt_r;
      reg        pulse_r;
      wire [3:0] divisor;

      assign divisor = auxiliary_clock_prescaler_r[g*4+3:g*4];

      always @(posedge clk)
      begin
        if (!rst_b || !aux_run[g])
        begin
          cnt_r   <= 4'h0;
          pulse_r <= 1'b0;
        end
        else
        begin
          pulse_r <= 1'b0;
          if (main_tick)
          begin
            if (cnt_r >= divisor)
            begin
              cnt_r   <= 4'h0;
              pulse_r <= 1'b1;
            end
            else
              cnt_r <= cnt_r + 4'h1;
          end
        end
      end
      assign aux_pulse[g] = pulse_r;
    end
  endgenerate

  // ****************************************
  // Outputs to aux clocks, PLL and interrupt
  // ****************************************
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      aux1_clk_en <= 1'b0;
      aux2_clk_en <= 1'b0;
      pll_stop    <= 1'b1;
      pll_mult    <= `PLL_MODE_4X;
      irq         <= 1'b0;
    end
    else
    begin
      aux1_clk_en <= aux_pulse[0] & aux_run[0];
      aux2_clk_en <= aux_pulse[1] & aux_run[1];
      pll_stop    <= pll_power_down_r;
      pll_mult    <= fast_clock_prescaler_r[`PLL_MODE_MSB:`PLL_MODE_LSB];
      irq         <= |(irq_status_r & irq_enable_r);
    end
  end

endmodule
`default_nettype wire

/* File: clock_ctl_regs.vh */
// Register map, field layout, reset values and constants of the clock control block
// What this block does
// - Slow select: 0 prescaled main, 1 32k
// - Fast select: 0 PLL, 1 main; reset 1
// - No PLL select while PLL powered down
// - No PLL select before PLL is stable
// - Unstable PLL makes PLL select no-op
// - Power-down bit stops PLL; resets 1
// - No power-down while PLL is selected
// - Aux clock 1 runs if enabled, stable
// - Aux clock 2 runs if enabled, stable
// - Power-on flag set by detect, cleared by 0
// - System clock is source over divisor+1
// - Multiply codes 011/100/101; reset 100
// - Fast prescaler resets 4Fh unless programming
// - Slow clock is main over 2(divisor+1)
// - Aux clock 1 is main over divisor+1
// - Aux clock 2 is main over divisor+1
// - Aux prescaler resets to FFh
`ifndef CLOCK_CTL_REGS_VH
`define CLOCK_CTL_REGS_VH

// ****************************************
// Register indices
// ****************************************
`define ADDR_CLOCK_RESET_CONTROL 3'h0
`define ADDR_FAST_CLOCK_PRESCALER 3'h1
`define ADDR_SLOW_CLOCK_PRESCALER 3'h2
`define ADDR_AUX_CLOCK_PRESCALER 3'h3
`define ADDR_IRQ_STATUS 3'h4
`define ADDR_IRQ_ENABLE 3'h5
`define ADDR_IRQ_CLEAR 3'h6

// ****************************************
// Control register fields
// ****************************************
`define BIT_SLOW_SELECT 0
`define BIT_FAST_SOURCE_SELECT 1
`define BIT_PLL_POWER_DOWN 2
`define BIT_AUX1_ENABLE 3
`define BIT_AUX2_ENABLE 4
`define BIT_POWER_ON 5
`define CONTROL_RESET 8'h26

// ****************************************
// Prescaler fields and reset values
// ****************************************
`define FAST_DIV_MSB 3
`define FAST_DIV_LSB 0
`define PLL_MODE_MSB 6
`define PLL_MODE_LSB 4
`define FAST_PRESCALER_RESET 8'h4F
`define SLOW_PRESCALER_RESET 8'hB6
`define AUX_PRESCALER_RESET 8'hFF
`define PLL_MODE_3X 3'h3
`define PLL_MODE_4X 3'h4
`define PLL_MODE_5X 3'h5

// ****************************************
// Interrupt status bits
// ****************************************
`define IRQ_PLL_SELECTED 0
`define IRQ_WRITE_REFUSED 1
`define IRQ_POWER_ON 2
`define IRQ_WIDTH 3

`endif

/* File: clock_ctl_sva.sv */
// Assertion checker for the clock control block
`timescale 1ns/1ps
`default_nettype none
module clock_ctl_sva
(
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       main_stable,
  input wire logic       sys_clk_en,
  input wire logic       aux1_clk_en,
  input wire logic       aux2_clk_en,
  input wire logic       pll_stop,
  input wire logic [2:0] pll_mult,
  input wire logic       irq
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  a_rdata_idle_zero: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data not zero outside read");
  a_unmapped_read: assert property (rd && addr == 3'h7 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_stop_after_write: assert property ($changed(pll_stop) |-> $past(wr && addr == 3'h0, 2))
    else $error("power-down output moved without control write");
  a_mult_after_write: assert property ($changed(pll_mult) |-> $past(wr && addr == 3'h1, 2))
    else $error("multiply output moved without prescaler write");
  a_aux_unstable_stop: assert property ((!main_stable)[*5] |-> !aux1_clk_en && !aux2_clk_en)
    else $error("aux clock ran with unstable main clock");
  a_sys_pulse_single: assert property (sys_clk_en |=> !sys_clk_en)
    else $error("system enable longer than one cycle");
  a_irq_masked_low: assert property (wr && addr == 3'h5 && wdata == 8'h00 |-> ##[1:2] !irq)
    else $error("interrupt high with all enables clear");
  a_reset_outputs: assert property ($rose(rst_b) |-> pll_stop && pll_mult == 3'h4 && !irq)
    else $error("outputs wrong after reset");

  c_irq: cover property (irq);
  c_aux1: cover property (aux1_clk_en);
  c_pll_up: cover property ($fell(pll_stop));
endmodule

bind clock_ctl clock_ctl_sva chk_i (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .main_stable(main_stable), .sys_clk_en(sys_clk_en),
  .aux1_clk_en(aux1_clk_en), .aux2_clk_en(aux2_clk_en), .pll_stop(pll_stop),
  .pll_mult(pll_mult), .irq(irq));
`default_nettype wire

/* File: tb.sv */
// Self-checking testbench for the clock control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic       clk;
  logic       rst_b;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       main_pin = 1'b0;
  logic       osc_pin = 1'b0;
  logic       pll_pin = 1'b0;
  logic       pll_stable;
  logic       main_stable;
  logic       pwr_det;
  logic       programming_mode;
  logic [3:0] ens;
  logic       pll_stop;
  logic [2:0] pll_mult;
  logic       irq;
  int         n_mismatch;
  int         n_tests;
  int         cyc = 0;

  clock_ctl dut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .main_clk_pin(main_pin), .osc32k_pin(osc_pin), .pll_clk_pin(pll_pin),
    .pll_stable(pll_stable), .main_stable(main_stable), .power_on_detect(pwr_det),
    .programming_mode(programming_mode), .sys_clk_en(ens[0]), .slow_clk_en(ens[1]),
    .aux1_clk_en(ens[2]), .aux2_clk_en(ens[3]), .pll_stop(pll_stop), .pll_mult(pll_mult),
    .irq(irq));

  // ****************************************
  // Clock and source pins
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Pins move on the clock grid so tick spacing is exact
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc % 4 == 3) main_pin <= ~main_pin;
    if (cyc % 3 == 2) pll_pin <= ~pll_pin;
    if (cyc % 20 == 19) osc_pin <= ~osc_pin;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, e);
  endtask

  // Last of three pulses, so a counter restart does not skew it
  task automatic gap(input int k, input logic [7:0] e);
    int t0;
    int t1;
    int w;
    t0 = 0;
    t1 = 0;
    for (int i = 0; i < 3; i++)
    begin
      w = 0;
      do
      begin
        @(negedge clk);
        w++;
      end while (ens[k] !== 1'b1 && w < 500);
      t1 = t0;
      t0 = cyc;
    end
    chk(8'(t0 - t1), e);
  endtask

  task automatic quiet;
    int c;
    c = 0;
    repeat (2) @(posedge clk);
    repeat (100)
    begin
      @(negedge clk);
      c += ens[2] + ens[3];
    end
    chk(8'(c), 8'h00);
  endtask

  task automatic settle;
    @(posedge clk);
    @(negedge clk);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    {rst_b, addr, wdata, wr, rd, pll_stable, pwr_det} = '0;
    {main_stable, programming_mode, n_mismatch, n_tests} = {2'b10, 64'h0};
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    rd_chk(3'h0, 8'h26);
    rd_chk(3'h1, 8'h4F);
    rd_chk(3'h2, 8'hB6);
    rd_chk(3'h3, 8'hFF);
    rd_chk(3'h7, 8'h00);
    chk({4'h0, pll_stop, pll_mult}, 8'h0C);
    $display("reset test done");
    for (int m = 3; m < 6; m++)
    begin
      wr_reg(3'h1, 8'h03 | 8'(m << 4));
      settle();
      chk({5'h0, pll_mult}, 8'(m));
    end
    wr_reg(3'h0, 8'h06);
    rd_chk(3'h0, 8'h06);
    wr_reg(3'h0, 8'h26);
    rd_chk(3'h0, 8'h06);
    pwr_det <= 1'b1;
    repeat (6) @(posedge clk);
    pwr_det <= 1'b0;
    repeat (4) @(posedge clk);
    rd_chk(3'h0, 8'h26);
    wr_reg(3'h5, 8'h07);
    settle();
    chk({7'h0, irq}, 8'h01);
    rd_chk(3'h4, 8'h04);
    wr_reg(3'h4, 8'h00);
    rd_chk(3'h4, 8'h04);
    rd_chk(3'h5, 8'h07);
    wr_reg(3'h5, 8'h00);
    settle();
    chk({7'h0, irq}, 8'h00);
    wr_reg(3'h6, 8'h07);
    rd_chk(3'h4, 8'h00);
    $display("power-on and interrupt test done");
    wr_reg(3'h0, 8'h24);
    rd_chk(3'h0, 8'h26);
    rd_chk(3'h4, 8'h02);
    wr_reg(3'h0, 8'h22);
    settle();
    chk({7'h0, pll_stop}, 8'h00);
    gap(0, 8'h20);
    wr_reg(3'h0, 8'h20);
    rd_chk(3'h0, 8'h22);
    @(posedge clk);
    pll_stable <= 1'b1;
    repeat (4) @(posedge clk);
    wr_reg(3'h0, 8'h20);
    rd_chk(3'h0, 8'h20);
    gap(0, 8'h18);
    rd_chk(3'h4, 8'h03);
    wr_reg(3'h6, 8'h07);
    wr_reg(3'h0, 8'h24);
    rd_chk(3'h0, 8'h20);
    rd_chk(3'h4, 8'h02);
    wr_reg(3'h0, 8'h22);
    wr_reg(3'h0, 8'h26);
    $display("source switch test done");
    wr_reg(3'h2, 8'h02);
    gap(1, 8'h30);
    wr_reg(3'h0, 8'h27);
    gap(1, 8'h28);
    wr_reg(3'h3, 8'h42);
    wr_reg(3'h0, 8'h3E);
    gap(2, 8'h18);
    gap(3, 8'h28);
    main_stable <= 1'b0;
    repeat (4) @(posedge clk);
    quiet();
    main_stable <= 1'b1;
    wr_reg(3'h0, 8'h26);
    quiet();
    $display("divider test done");
    wr_reg(3'h1, 8'h45);
    programming_mode <= 1'b1;
    repeat (4) @(posedge clk);
    rst_b <= 1'b0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    rd_chk(3'h1, 8'h45);
    rd_chk(3'h2, 8'hB6);
    rd_chk(3'h0, 8'h26);
    chk({4'h0, pll_stop, pll_mult}, 8'h0C);
    $display("programming reset test done");
    final_report();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    final_report();
  end
endmodule
`default_nettype wire
